// File: core/reset_boot_mode_control_map.vh
// constants for the reset and boot-mode control block
`ifndef RESET_BOOT_MODE_CONTROL_MAP_VH
`define RESET_BOOT_MODE_CONTROL_MAP_VH
`define STRAP_WINDOW_CYCLES   4'ha
`define FIRST_FETCH_CYCLES    7'h50
`define INT_TOP_ADDR_BIT      22
`define INT_REGION_CODE       10'h000
`define PERIPH_REGION_CODE    10'h3ff
`define PRIMARY_SRAM_BYTES    8192
`define EXT_SRAM_BASE         32'h0010_0000
`define EXT_SRAM_BYTES        131072
`define VECTOR_TOP_ADDR       32'h0000_0020
`define REGION_INTERNAL       2'h0
`define REGION_EXTERNAL       2'h1
`define REGION_PERIPH         2'h2
`define BOOT_EXT_CS0          1'h0
`define BOOT_EXT_SRAM         1'h1
`define ZONE_PRIMARY          3'h0
`define ZONE_EXT_SRAM         3'h1
`define ZONE_EXT_CS0          3'h2
`define ZONE_OTHER            3'h3
`endif

// File: core/reset_boot_mode_control.v
// reset sequencing, strap sampling, clock-out gating and address decode
`include "reset_boot_mode_control_map.vh"
`default_nettype none
module reset_boot_mode_control #(
	parameter N_PINS = 32
) (
	input  wire              clk_i,
	input  wire              reset_i,
	input  wire              external_reset_n_i,
	input  wire              watchdog_reset_i,
	input  wire              boot_select_pin_i,
	input  wire              tristate_select_n_i,
	input  wire              remap_command_bit_i,
	input  wire [31:0]       addr_i,
	input  wire              access_i,
	input  wire              write_i,
	input  wire [1:0]        size_i,
	input  wire [N_PINS-1:0] pin_out_i,
	input  wire [N_PINS-1:0] pin_drive_i,
	output wire              sys_reset_o,
	output wire              periph_reset_o,
	output reg               fetch_enable_o,
	output wire [31:0]       fetch_addr_o,
	output wire              master_clock_out_o,
	output reg               boot_mode_o,
	output reg               tristate_mode_o,
	output reg               remapped_o,
	output reg  [1:0]        region_o,
	output reg  [2:0]        zone_o,
	output reg  [3:0]        byte_lanes_o,
	output wire              chip_select_zero_n_o,
	output reg               ext_sram_write_o,
	output wire [N_PINS-1:0] pin_o,
	output wire [N_PINS-1:0] pin_oe_n_o
);
	localparam [6:0] FETCH_CNT = `FIRST_FETCH_CYCLES;
	localparam [3:0] STRAP_CNT = `STRAP_WINDOW_CYCLES;
	localparam [31:0] PRI_MASK = `PRIMARY_SRAM_BYTES - 1;
	localparam [31:0] EXT_MASK = `EXT_SRAM_BYTES - 1;

	reg        rst_meta_q;
	reg        rst_sync_q;
	always @(posedge clk_i or negedge external_reset_n_i)
	begin
		if (!external_reset_n_i)
		begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end
		else
		begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	wire ext_rst = reset_i | ~rst_sync_q;

	// external reset or watchdog, each on its own, holds the system in reset
	wire any_rst = ext_rst | watchdog_reset_i;
	// peripheral registers restored on any reset
	assign sys_reset_o = any_rst;
	assign periph_reset_o = any_rst;

	// a strap counts only once its level held for the whole window
	function run_full;
		input [3:0] cnt;
		begin
			run_full = (cnt == STRAP_CNT);
		end
	endfunction

	// saturating run counter; any break in the level restarts it
	function [3:0] strap_step;
		input [3:0] cnt;
		input       hold;
		begin
			if (!hold)
				strap_step = 4'h0;
			else if (run_full(cnt))
				strap_step = cnt;
			else
				strap_step = cnt + 4'h1;
		end
	endfunction

	// strap run counters over trailing cycles of reset
	// boot level must be stable for the last ten cycles
	reg [3:0] tri_low_q;
	reg [3:0] boot_hi_q;
	always @(posedge clk_i)
	begin
		if (!ext_rst)
		begin
			tri_low_q <= 4'h0;
			boot_hi_q <= 4'h0;
		end
		else
		begin
			tri_low_q <= strap_step(tri_low_q, !tristate_select_n_i);
			boot_hi_q <= strap_step(boot_hi_q, boot_select_pin_i);
		end
	end

	// latch straps at external release; watchdog reset keeps them
	reg ext_rst_q;
	always @(posedge clk_i)
	begin
		ext_rst_q <= ext_rst;
	end
	wire ext_release = ext_rst_q & ~ext_rst;

	always @(posedge clk_i)
	begin
		if (reset_i)
		begin
			boot_mode_o <= `BOOT_EXT_CS0;
			tristate_mode_o <= 1'b0;
		end
		// straps sampled only on external release
		else if (ext_release)
		begin
			// level zero boots external cs0
			// an unsettled boot level falls back to external memory
			boot_mode_o <= run_full(boot_hi_q) ?
				`BOOT_EXT_SRAM : `BOOT_EXT_CS0;
			// straps are judged on counts up to the cycle before release
			tristate_mode_o <= run_full(tri_low_q);
		end
	end

	// count release cycles to first fetch
	localparam [0:0] SEQ_COUNT = 1'h0;
	localparam [0:0] SEQ_RUN   = 1'h1;
	reg       seq_q;
	reg [6:0] fetch_cnt_q;
	always @(posedge clk_i)
	begin
		if (any_rst)
		begin
			seq_q <= SEQ_COUNT;
			fetch_cnt_q <= 7'h00;
			fetch_enable_o <= 1'b0;
		end
		else
		begin
			case (seq_q)
				SEQ_COUNT:
				begin
					if (fetch_cnt_q == FETCH_CNT - 7'h1)
					begin
						seq_q <= SEQ_RUN;
						fetch_enable_o <= 1'b1;
					end
					else
						fetch_cnt_q <= fetch_cnt_q + 7'h1;
				end
				SEQ_RUN:
					fetch_enable_o <= 1'b1;
				default:
					seq_q <= SEQ_COUNT;
			endcase
		end
	end
	// next fetch after any reset is address zero
	assign fetch_addr_o = 32'h0000_0000;

	// clock output gated low during external reset
	// gating is a plain and; the pad sees a one-gate skew
	reg mck_en_q;
	always @(posedge clk_i)
	begin
		mck_en_q <= ~ext_rst;
	end
	// the async reset term stops the clock at once, not at the next edge
	assign master_clock_out_o = clk_i & mck_en_q & ~ext_rst;

	// remap set by command, cleared by any reset
	always @(posedge clk_i)
	begin
		if (any_rst)
			remapped_o <= 1'b0;
		else if (remap_command_bit_i)
			remapped_o <= 1'b1;
	end

	function [1:0] region_of;
		input [31:0] a;
		begin
			if (a[31:`INT_TOP_ADDR_BIT] == `INT_REGION_CODE)
				region_of = `REGION_INTERNAL;
			else if (a[31:`INT_TOP_ADDR_BIT] == `PERIPH_REGION_CODE)
				region_of = `REGION_PERIPH;
			else
				region_of = `REGION_EXTERNAL;
		end
	endfunction

	function in_ext_sram;
		input [31:0] a;
		begin
			in_ext_sram = ((a & ~EXT_MASK) == `EXT_SRAM_BASE);
		end
	endfunction

	reg [1:0] reg_d;
	reg [2:0] zone_d;
	reg [3:0] lanes_d;
	always @*
	begin
		reg_d = region_of(addr_i);
		zone_d = `ZONE_OTHER;
		if (reg_d == `REGION_INTERNAL)
		begin
			// extended bank at its fixed base
			if (in_ext_sram(addr_i))
				zone_d = `ZONE_EXT_SRAM;
			// primary sram at zero once remapped
			else if (remapped_o && ((addr_i & ~PRI_MASK) == 32'h0))
				zone_d = `ZONE_PRIMARY;
			// boot memory aliased at zero before remap
			else if (!remapped_o && (addr_i < `EXT_SRAM_BASE))
				zone_d = (boot_mode_o == `BOOT_EXT_SRAM) ?
					`ZONE_EXT_SRAM : `ZONE_EXT_CS0;
		end
		// byte, half and word in one cycle
		case (size_i)
			2'h0: lanes_d = 4'h1 << addr_i[1:0];
			2'h1: lanes_d = addr_i[1] ? 4'hc : 4'h3;
			default: lanes_d = 4'hf;
		endcase
		// peripherals are word-only
		if (reg_d == `REGION_PERIPH)
			lanes_d = 4'hf;
	end

	always @(posedge clk_i)
	begin
		if (any_rst)
		begin
			region_o <= `REGION_INTERNAL;
			zone_o <= `ZONE_OTHER;
			byte_lanes_o <= 4'h0;
			ext_sram_write_o <= 1'b0;
		end
		else
		begin
			region_o <= reg_d;
			zone_o <= access_i ? zone_d : `ZONE_OTHER;
			byte_lanes_o <= access_i ? lanes_d : 4'h0;
			// flag writes landing in extended sram
			ext_sram_write_o <= access_i & write_i &
				(zone_d == `ZONE_EXT_SRAM);
		end
	end
	// decoded from the registered zone, so the select cannot glitch
	assign chip_select_zero_n_o = ~(zone_o == `ZONE_EXT_CS0);

	// tristate mode kills every pad driver
	// pads are inputs while in reset
	// pad 21 carries io21, serial1 tx and tristate select
	// pad 24 doubles as boot select during reset
	// pad data is registered; the enable stays combinational so that a
	// reset frees every pad at once, ahead of the data path
	reg [N_PINS-1:0] pin_q;
	always @(posedge clk_i)
	begin
		pin_q <= pin_out_i;
	end
	assign pin_o = pin_q;
	genvar g;
	generate
		for (g = 0; g < N_PINS; g = g + 1)
		begin : pad
			assign pin_oe_n_o[g] = ~(pin_drive_i[g] & ~any_rst &
				~tristate_mode_o);
		end
	endgenerate
endmodule
`default_nettype wire

// File: dv/reset_boot_mode_control_asserts.sv
// port assertions for the reset and boot-mode control block
`default_nettype none
module reset_boot_mode_control_asserts #(
	parameter N_PINS = 32
) (
	input wire logic		clk_i,
	input wire logic		reset_i,
	input wire logic		sys_reset_o,
	input wire logic		fetch_enable_o,
	input wire logic [31:0]	fetch_addr_o,
	input wire logic		tristate_mode_o,
	input wire logic [N_PINS-1:0]	pin_oe_n_o,
	input wire logic		remapped_o,
	input wire logic		remap_command_bit_i,
	input wire logic		access_i,
	input wire logic		write_i,
	input wire logic [31:0]	addr_i,
	input wire logic		ext_sram_write_o,
	input wire logic [1:0]	region_o,
	input wire logic [3:0]	byte_lanes_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [6:0]	cnt_q;
	// cycles since release, frozen once the fetch starts
	always_ff @(posedge clk_i)
		cnt_q <= sys_reset_o ? 7'h00 : cnt_q + {6'h00, !fetch_enable_o};
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence s_release;
		$fell(sys_reset_o);
	endsequence
	sequence s_live;
		access_i && !sys_reset_o;
	endsequence
	a_fetch_hold: assert property (s_release |-> !fetch_enable_o [*8])
		else $error("fetch too early");
	a_fetch_delay: assert property ($rose(fetch_enable_o) |-> cnt_q == 7'h50)
		else $error("fetch delay wrong");
	a_fetch_zero: assert property (fetch_addr_o == 32'h0)
		else $error("fetch address not zero");
	a_reset_pads: assert property (sys_reset_o |-> &pin_oe_n_o)
		else $error("pad driven in reset");
	a_reset_fetch: assert property (sys_reset_o |=> !fetch_enable_o)
		else $error("fetch active after reset");
	a_tristate_off: assert property (tristate_mode_o |-> &pin_oe_n_o)
		else $error("pad driven in tristate");
	a_remap_set: assert property (remap_command_bit_i && !sys_reset_o |=> remapped_o)
		else $error("remap not taken");
	a_remap_kept: assert property (remapped_o && !sys_reset_o |=> remapped_o)
		else $error("remap lost");
	a_sram_write: assert property (s_live ##0 write_i && addr_i[31:17] == 15'h0008 |=> ext_sram_write_o)
		else $error("extended write missed");
	a_periph_word: assert property (s_live ##0 &addr_i[31:22] |=> region_o == 2'h2 && byte_lanes_o == 4'hf)
		else $error("peripheral decode wrong");
endmodule
bind reset_boot_mode_control reset_boot_mode_control_asserts #(.N_PINS(N_PINS)) chk_u (.*);
`default_nettype wire

// File: dv/board_reset_model.sv
// board reset circuit and strap jumpers facing the block
`default_nettype none
module board_reset_model (
	input wire logic	clk_i,
	output var logic	external_reset_n_o,
	output var logic	boot_select_pin_o,
	output var logic	tristate_select_n_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		external_reset_n_o = 1'h1;
		boot_select_pin_o = 1'h0;
		tristate_select_n_o = 1'h1;
	end
	// clock runs, straps settle well before release
	task automatic strap_reset(input logic b, input logic t);
		@(negedge clk_i);
		external_reset_n_o = 1'h0;
		boot_select_pin_o = b;
		tristate_select_n_o = t;
		repeat (16) @(negedge clk_i);
		external_reset_n_o = 1'h1;
		repeat (3) @(negedge clk_i);
		// pads become io lines again, so the strap level is gone
		boot_select_pin_o = !b;
		tristate_select_n_o = !t;
	endtask
endmodule
`default_nettype wire

// File: dv/reset_boot_mode_control_bench.sv
// self-checking bench for the reset and boot-mode control block
`include "reset_boot_mode_control_map.vh"
`default_nettype none
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin errors++; \
	$display("Error at %0t: %h vs %h", $time, a, b); end end
module reset_boot_mode_control_bench;
	timeunit 1ns;
	timeprecision 1ps;
	int	errors = 0, compares = 0, n;
	logic	clk_i = 1'h0, reset_i = 1'h1, watchdog_reset_i = 1'h0;
	logic	remap_command_bit_i = 1'h0, access_i = 1'h0, write_i = 1'h0;
	logic [1:0]	size_i = 2'h0;
	logic [31:0]	addr_i = 32'h0, pin_out_i = 32'h5a3c_96e1;
	logic [31:0]	pin_drive_i = 32'h00ff_0f0f;
	wire	external_reset_n_i, boot_select_pin_i, tristate_select_n_i;
	wire	sys_reset_o, periph_reset_o, fetch_enable_o, master_clock_out_o;
	wire	boot_mode_o, tristate_mode_o, remapped_o, ext_sram_write_o;
	wire	chip_select_zero_n_o;
	wire [31:0]	fetch_addr_o, pin_o, pin_oe_n_o;
	wire [1:0]	region_o;
	wire [2:0]	zone_o;
	wire [3:0]	byte_lanes_o;
	always #2.5 clk_i = ~clk_i;
	reset_boot_mode_control dut_u (.*);
	board_reset_model board_u (.clk_i(clk_i),
		.external_reset_n_o(external_reset_n_i),
		.boot_select_pin_o(boot_select_pin_i),
		.tristate_select_n_o(tristate_select_n_i));
	task automatic acc(input logic [31:0] a, input logic [1:0] s, input logic w);
		@(negedge clk_i);
		addr_i = a;
		size_i = s;
		write_i = w;
		access_i = 1'h1;
		@(negedge clk_i);
		access_i = 1'h0;
	endtask
	task automatic run_reset(input logic ext, wd, b, t);
		if (ext)
			fork board_u.strap_reset(b, t); join_none
		if (wd)
			watchdog_reset_i = 1'h1;
		repeat (8) @(posedge clk_i);
		#1 `CHK({pin_oe_n_o, fetch_enable_o}, {32'hffff_ffff, 1'h0})
		`CHK({sys_reset_o, periph_reset_o, fetch_addr_o}, {2'h3, 32'h0})
		if (ext)
			`CHK(master_clock_out_o, 1'h0)
		@(negedge clk_i);
		watchdog_reset_i = 1'h0;
		for (n = 0; sys_reset_o !== 1'h0 && n < 60; n++)
			@(negedge clk_i);
		for (n = 0; fetch_enable_o !== 1'h1 && n < 200; n++)
			@(negedge clk_i);
		if (ext)
			`CHK(n, `FIRST_FETCH_CYCLES)
		`CHK({boot_mode_o, tristate_mode_o, remapped_o}, {b, !t, 1'h0})
		`CHK(pin_oe_n_o, t ? ~pin_drive_i : 32'hffff_ffff)
		`CHK(pin_o, pin_out_i)
		@(posedge clk_i);
		#1 `CHK(master_clock_out_o, 1'h1)
	endtask
	task automatic t_map(input logic b);
		acc(32'h0000_0010, 2'h2, 1'h0);
		`CHK(zone_o, b ? `ZONE_EXT_SRAM : `ZONE_EXT_CS0)
		`CHK(chip_select_zero_n_o, b)
		remap_command_bit_i = 1'h1;
		acc(32'h0000_0003, 2'h0, 1'h1);
		remap_command_bit_i = 1'h0;
		`CHK({remapped_o, zone_o, byte_lanes_o}, {1'h1, `ZONE_PRIMARY, 4'h8})
		acc(32'h0011_fffe, 2'h1, 1'h1);
		`CHK({ext_sram_write_o, zone_o}, {1'h1, `ZONE_EXT_SRAM})
		`CHK(byte_lanes_o, 4'hc)
		acc(32'hffc0_0001, 2'h0, 1'h0);
		`CHK({ext_sram_write_o, region_o}, {1'h0, `REGION_PERIPH})
	endtask
	task automatic conclude();
		$display("errors %0d compares %0d", errors, compares);
		if (errors == 0 && compares > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial
	begin
		#20000;
		errors++;
		conclude();
	end
	initial
	begin
		repeat (20) @(negedge clk_i);
		reset_i = 1'h0;
		run_reset(1'h1, 1'h0, 1'h0, 1'h1);
		t_map(1'h0);
		run_reset(1'h1, 1'h0, 1'h1, 1'h0);
		run_reset(1'h1, 1'h0, 1'h1, 1'h1);
		t_map(1'h1);
		run_reset(1'h0, 1'h1, 1'h1, 1'h1);
		run_reset(1'h1, 1'h1, 1'h0, 1'h1);
		conclude();
	end
endmodule
`default_nettype wire
